// ===== verilog/pin_defaults_pkg.sv
package pin_defaults_pkg;
    // pin group sizes and the position of the pins shared with transmit data
    localparam int GP_PINS = 7;
    localparam int SHARED_LO = 3;
    localparam int SHARED_N = 4;
    localparam int STATUS_PINS = 2;

    // general pin function codes
    localparam logic [1:0] FN_DEFAULT = 2'h0;
    localparam logic [1:0] FN_INPUT = 2'h1;
    localparam logic [1:0] FN_OUTPUT = 2'h2;
    localparam logic [1:0] FN_CLOCK = 2'h3;

    // status pin function codes
    localparam logic [1:0] ST_DEFAULT = 2'h0;
    localparam logic [1:0] ST_LOW = 2'h1;
    localparam logic [1:0] ST_HIGH = 2'h2;
    localparam logic [1:0] ST_SWAP = 2'h3;

    // parallel interface modes, one-hot
    typedef enum logic [2:0] {
        PAR_GMII = 3'h1,
        PAR_MII = 3'h2,
        PAR_RGMII = 3'h4
    } par_mode_t;

    // values after reset
    localparam logic [STATUS_PINS-1:0] STRAP_RST = 2'h0;
    localparam logic [GP_PINS-1:0] GP_RST = 7'h00;
    localparam logic [SHARED_N-1:0] TXD_RST = 4'h0;

    // clock rates and the half period of the generated clock in cycles
    localparam longint CLK_HZ = 100_000_000;
    localparam longint CLK125_HZ = 125_000_000;
    localparam longint HALF_RAW = CLK_HZ / (2 * CLK125_HZ);
    localparam int CLK125_HALF_CYC = (HALF_RAW < 1) ? 1 : int'(HALF_RAW);
endpackage

// ===== verilog/strap_capture.sv
`timescale 1ns/1ps
module strap_capture
#(
    parameter int W = 2
)
(
    input wire logic clk_i,             // system clock
    input wire logic resetn_i,          // async reset, active low
    input wire logic [W-1:0] pins_i,    // strap pin levels
    output logic [W-1:0] straps_o,      // captured levels
    output logic done_o                 // capture finished
);
    import pin_defaults_pkg::*;

    // capture once, on the first edge after reset release
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            straps_o <= W'(STRAP_RST);
            done_o <= 1'b0;
        end
        else if (!done_o)
        begin
            straps_o <= pins_i;
            done_o <= 1'b1;
        end
    end
endmodule

// ===== verilog/general_pin_defaults.sv
`timescale 1ns/1ps
module general_pin_defaults
#(
    parameter int GP_PINS = 7,
    parameter int CLK_DIV_W = 8
)
(
    input wire logic clk_i,                                 // system clock
    input wire logic resetn_i,                              // async reset, active low
    input wire logic link_up_i,                             // link state
    input wire logic crs_i,                                 // carrier sense
    input wire pin_defaults_pkg::par_mode_t par_mode_i,     // parallel interface mode
    input wire logic [1:0] status_first_func_i,             // first status pin function
    input wire logic [1:0] status_second_func_i,            // second status pin function
    input wire logic [2*GP_PINS-1:0] general_func_i,        // two bits per general pin
    input wire logic [GP_PINS-1:0] general_out_i,           // software output levels
    input wire logic status_out_first_i,                    // first status pad level
    output logic status_out_first_o,                        // first status pad drive
    output logic status_out_first_oe_o,                     // first status pad enable
    input wire logic status_out_second_i,                   // second status pad level
    output logic status_out_second_o,                       // second status pad drive
    output logic status_out_second_oe_o,                    // second status pad enable
    input wire logic [GP_PINS-1:0] general_pin_i,           // general pad levels
    output logic [GP_PINS-1:0] general_pin_o,               // general pad drive
    output logic [GP_PINS-1:0] general_pin_oe_o,            // general pad enables
    output logic [GP_PINS-1:0] general_in_o,                // sampled general pad levels
    output logic [pin_defaults_pkg::SHARED_N-1:0] txd_upper_o, // transmit data bits 4..7
    output logic [pin_defaults_pkg::STATUS_PINS-1:0] strap_o   // captured strap levels
);
    import pin_defaults_pkg::*;

    // general pin drive: {enable, level}
    function automatic logic [1:0] pin_drive(input logic [1:0] func, input logic dflt_clk,
                                             input logic out_bit, input logic clk_bit);
        logic [1:0] r;
        r = 2'h0;
        case (func)
            FN_DEFAULT: r = dflt_clk ? {1'b1, clk_bit} : 2'h0;
            FN_INPUT: r = 2'h0;
            FN_OUTPUT: r = {1'b1, out_bit};
            FN_CLOCK: r = {1'b1, clk_bit};
            default: r = 2'h0;
        endcase
        return r;
    endfunction

    // status pin level for a function code
    function automatic logic status_drive(input logic [1:0] func, input logic dflt,
                                          input logic other);
        logic r;
        r = 1'b0;
        case (func)
            ST_DEFAULT: r = dflt;
            ST_LOW: r = 1'b0;
            ST_HIGH: r = 1'b1;
            ST_SWAP: r = other;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    logic strap_done;
    logic [STATUS_PINS-1:0] straps;
    logic [CLK_DIV_W-1:0] div_cnt_r;
    logic [CLK_DIV_W-1:0] div_cnt_nxt;
    logic clk_tgl_r;
    logic clk_tgl_nxt;
    logic div_wrap;
    logic shared_ok;
    logic st_first_nxt;
    logic st_second_nxt;
    logic [GP_PINS-1:0] gp_oe_nxt;
    logic [GP_PINS-1:0] gp_val_nxt;
    logic [SHARED_N-1:0] txd_nxt;

    // status pads are straps until the capture is done
    strap_capture #(
        .W(STATUS_PINS)
    ) u_strap (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pins_i({status_out_second_i, status_out_first_i}),
        .straps_o(straps),
        .done_o(strap_done)
    );

    // clock divider for the clock output; at this system rate it runs at half clk_i
    assign div_wrap = (div_cnt_r == CLK_DIV_W'(CLK125_HALF_CYC - 1));
    assign div_cnt_nxt = div_wrap ? '0 : div_cnt_r + CLK_DIV_W'(1);
    assign clk_tgl_nxt = div_wrap ? ~clk_tgl_r : clk_tgl_r;

    // shared pads serve as general pins only outside GMII
    assign shared_ok = (par_mode_i != PAR_GMII);
    assign txd_nxt = shared_ok ? TXD_RST : general_pin_i[SHARED_LO +: SHARED_N];

    // status pin levels from function select
    assign st_first_nxt = status_drive(status_first_func_i, link_up_i, crs_i);
    assign st_second_nxt = status_drive(status_second_func_i, crs_i, link_up_i);

    // per general pin drive, default clock only on the first pin with strap high
    genvar g;
    generate
        for (g = 0; g < GP_PINS; g = g + 1)
        begin : g_pin
            logic [1:0] drv;
            logic blocked;
            assign drv = pin_drive(general_func_i[2*g +: 2],
                                   (g == 0) ? straps[0] : 1'b0,
                                   general_out_i[g], clk_tgl_nxt);
            assign blocked = (g >= SHARED_LO) && !shared_ok;
            assign gp_oe_nxt[g] = strap_done && drv[1] && !blocked;
            assign gp_val_nxt[g] = gp_oe_nxt[g] & drv[0];
        end
    endgenerate

    // divider state
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            div_cnt_r <= '0;
            clk_tgl_r <= 1'b0;
        end
        else
        begin
            div_cnt_r <= div_cnt_nxt;
            clk_tgl_r <= clk_tgl_nxt;
        end
    end

    // registered pad outputs; everything cleared by reset
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            status_out_first_o <= 1'b0;
            status_out_first_oe_o <= 1'b0;
            status_out_second_o <= 1'b0;
            status_out_second_oe_o <= 1'b0;
            general_pin_o <= GP_PINS'(GP_RST);
            general_pin_oe_o <= GP_PINS'(GP_RST);
            general_in_o <= GP_PINS'(GP_RST);
            txd_upper_o <= TXD_RST;
            strap_o <= STRAP_RST;
        end
        else
        begin
            status_out_first_o <= strap_done & st_first_nxt;
            status_out_first_oe_o <= strap_done;
            status_out_second_o <= strap_done & st_second_nxt;
            status_out_second_oe_o <= strap_done;
            general_pin_o <= gp_val_nxt;
            general_pin_oe_o <= gp_oe_nxt;
            general_in_o <= general_pin_i;
            txd_upper_o <= txd_nxt;
            strap_o <= straps;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_release;
        !strap_done ##1 strap_done;
    endsequence

    property p_link_default;
        (strap_done && status_first_func_i == ST_DEFAULT)
            |=> status_out_first_oe_o && status_out_first_o == $past(link_up_i);
    endproperty
    a_link_default: assert property (p_link_default)
        else $error("first status pin not showing link state");

    property p_crs_default;
        (strap_done && status_second_func_i == ST_DEFAULT)
            |=> status_out_second_oe_o && status_out_second_o == $past(crs_i);
    endproperty
    a_crs_default: assert property (p_crs_default)
        else $error("second status pin not showing carrier sense");

    property p_pin1_hiz;
        (strap_done && !straps[0] && general_func_i[1:0] == FN_DEFAULT)
            |=> !general_pin_oe_o[0];
    endproperty
    a_pin1_hiz: assert property (p_pin1_hiz)
        else $error("first general pin driven with strap low");

    property p_pin1_clock;
        (strap_done && straps[0] && general_func_i[1:0] == FN_DEFAULT) [*2]
            |=> general_pin_oe_o[0] && general_pin_o[0] != $past(general_pin_o[0]);
    endproperty
    a_pin1_clock: assert property (p_pin1_clock)
        else $error("first general pin not toggling with strap high");

    property p_rest_hiz;
        s_release ##0 (general_func_i[2*GP_PINS-1:2] == '0)
            |=> general_pin_oe_o[GP_PINS-1:1] == '0;
    endproperty
    a_rest_hiz: assert property (p_rest_hiz)
        else $error("general pins two to seven driven after reset");

    property p_gmii_block;
        (par_mode_i == PAR_GMII) |=> general_pin_oe_o[SHARED_LO +: SHARED_N] == '0
            && txd_upper_o == $past(general_pin_i[SHARED_LO +: SHARED_N]);
    endproperty
    a_gmii_block: assert property (p_gmii_block)
        else $error("shared pins not carrying transmit data in GMII");

    property p_sw_override;
        (strap_done && status_first_func_i == ST_HIGH && general_func_i[3:2] == FN_OUTPUT)
            |=> status_out_first_o && general_pin_oe_o[1]
            && general_pin_o[1] == $past(general_out_i[1]);
    endproperty
    a_sw_override: assert property (p_sw_override)
        else $error("software function select not applied");

    property p_input_mode;
        (general_func_i[5:4] == FN_INPUT)
            |=> !general_pin_oe_o[2] && general_in_o[2] == $past(general_pin_i[2]);
    endproperty
    a_input_mode: assert property (p_input_mode)
        else $error("input mode pin driven or not sampled");

    property p_strap_capture;
        s_release |-> straps == $past({status_out_second_i, status_out_first_i})
            && !status_out_first_oe_o ##1 (status_out_first_oe_o && status_out_second_oe_o);
    endproperty
    a_strap_capture: assert property (p_strap_capture)
        else $error("strap capture or status enable sequence wrong");
endmodule

// ===== verif/pad_board_model.sv
`timescale 1ns/1ps
// board side of the pads: strap resistors, external drivers and floating pads
module pad_board_model
(
    input wire logic clk_i,             // system clock
    input wire logic [1:0] strap_val_i, // strap levels {second,first}
    input wire logic strap_en_i,        // board holds the straps
    input wire logic [6:0] ext_val_i,   // board levels on general pads
    input wire logic [6:0] ext_en_i,    // board drives general pads
    input wire logic [1:0] st_o_i,      // device status drive
    input wire logic [1:0] st_oe_i,     // device status enables
    input wire logic [6:0] gp_o_i,      // device general drive
    input wire logic [6:0] gp_oe_i,     // device general enables
    output logic [1:0] st_pad_o,        // status pad levels
    output logic [6:0] gp_pad_o         // general pad levels
);
    logic [8:0] wander_r = 9'h0AA;

    // undriven pads change every cycle so a stale level never passes as a drive
    always_ff @(posedge clk_i)
    begin
        wander_r <= ~wander_r;
    end

    // straps only while the board holds them, device drive wins over them whenever enabled
    assign st_pad_o = (st_oe_i & st_o_i)
        | (~st_oe_i & (strap_en_i ? strap_val_i : wander_r[1:0]));
    // general pads: device, else board, else floating
    assign gp_pad_o = (gp_oe_i & gp_o_i) | (~gp_oe_i & ext_en_i & ext_val_i)
        | (~gp_oe_i & ~ext_en_i & wander_r[8:2]);
endmodule

// ===== verif/general_pin_defaults_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks++; if ((e) !== (s)) begin n_fail++; \
    $display("BAD %s expected %h seen %h", nm, e, s); end end
module general_pin_defaults_test;
    import pin_defaults_pkg::*;
    typedef struct {string nm; int id; logic [15:0] v; int due;} note_t;
    note_t notes[$];
    note_t nt;
    int cyc = 0, checks = 0, n_fail = 0;
    logic clk_i = 1'b0, resetn_i = 1'b0, link_up_i = 1'b0, crs_i = 1'b0, s1 = 1'b0;
    par_mode_t par_mode_i = PAR_MII;
    logic [1:0] sf1 = 2'h0, sf2 = 2'h0, strap_val = 2'h0, st_pad, st_o, st_oe, strap_o;
    logic strap_en = 1'b1;
    logic [13:0] gfunc = 14'h0000;
    logic [6:0] gout = 7'h00, ext_val = 7'h00, ext_en = 7'h00, gp_pad, gp_o, gp_oe, gin_o, prev_gp;
    logic [3:0] txd_o;

    general_pin_defaults #(.GP_PINS(7), .CLK_DIV_W(8)) dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .link_up_i(link_up_i), .crs_i(crs_i), .par_mode_i(par_mode_i),
        .status_first_func_i(sf1), .status_second_func_i(sf2), .general_func_i(gfunc),
        .general_out_i(gout), .status_out_first_i(st_pad[0]), .status_out_first_o(st_o[0]),
        .status_out_first_oe_o(st_oe[0]), .status_out_second_i(st_pad[1]),
        .status_out_second_o(st_o[1]), .status_out_second_oe_o(st_oe[1]),
        .general_pin_i(gp_pad), .general_pin_o(gp_o), .general_pin_oe_o(gp_oe),
        .general_in_o(gin_o), .txd_upper_o(txd_o), .strap_o(strap_o));
    pad_board_model board (.clk_i(clk_i), .strap_val_i(strap_val), .strap_en_i(strap_en),
        .ext_val_i(ext_val), .ext_en_i(ext_en), .st_o_i(st_o), .st_oe_i(st_oe), .gp_o_i(gp_o),
        .gp_oe_i(gp_oe), .st_pad_o(st_pad), .gp_pad_o(gp_pad));

    // free-running clock
    initial forever #5 clk_i = ~clk_i;

    // prints the counts and the verdict, then stops
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // cycle count and hang guard
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    // observed value for a note kind
    function automatic logic [15:0] seen(int id);
        case (id)
            0: return {12'h000, st_oe, st_o};
            1: return {9'h000, gp_oe};
            2: return {9'h000, gp_o};
            3: return {9'h000, gin_o};
            4: return {12'h000, txd_o};
            5: return {14'h0000, strap_o};
            default: return {9'h000, gp_o ^ prev_gp};
        endcase
    endfunction

    // watcher: takes due notes off the queue and compares with the outputs
    always @(negedge clk_i)
    begin
        while (notes.size() > 0 && notes[0].due <= cyc)
        begin
            nt = notes.pop_front();
            `CHK(nt.nm, nt.v, seen(nt.id))
        end
        prev_gp <= gp_o;
    end

    task automatic expect_val(string nm, int id, logic [15:0] v, int d);
        notes.push_back('{nm, id, v, cyc + d});
    endtask

    task automatic step(int n);
        repeat (n) @(negedge clk_i);
    endtask

    // expected status pin level for a function code
    function automatic logic st_exp(logic [1:0] f, logic mine, logic other);
        return (f == ST_LOW) ? 1'b0 : (f == ST_HIGH) ? 1'b1 : (f == ST_SWAP) ? other : mine;
    endfunction

    // reset with straps held on the status pads until the capture edge has passed
    task automatic do_reset(logic first, logic second);
        @(negedge clk_i);
        resetn_i = 1'b0;
        strap_val = {second, first};
        strap_en = 1'b1;
        expect_val("status in reset", 0, 16'h0000, 2);
        expect_val("enables in reset", 1, 16'h0000, 2);
        expect_val("straps in reset", 5, 16'h0000, 2);
        step(12);
        resetn_i = 1'b1;
        step(1);
        strap_en = 1'b0;
    endtask

    // one random round of general pin functions in the given mode
    task automatic gp_round(par_mode_t m);
        logic [6:0] om;
        par_mode_i = m;
        for (int p = 0; p < 7; p++)
        begin
            gfunc[2*p +: 2] = 2'($urandom_range(0, 2));
            om[p] = (gfunc[2*p +: 2] == FN_OUTPUT);
        end
        if (m == PAR_GMII)
            om[6:3] = 4'h0;
        gout = 7'($urandom);
        ext_val = 7'($urandom);
        ext_en = ~om;
        expect_val("general enables", 1, {9'h000, om}, 2);
        expect_val("general drive", 2, {9'h000, gout & om}, 2);
        expect_val("general inputs", 3,
            {9'h000, (gout & om) | (ext_val & ~om)}, 2);
        expect_val("shared data", 4,
            (m == PAR_GMII) ? {12'h000, ext_val[6:3]} : 16'h0000, 2);
        step(2);
    endtask

    // main sequence
    initial
    begin
        void'($urandom(56));
        for (int k = 0; k < 4; k++)
        begin
            s1 = ~k[0];
            link_up_i = 1'($urandom);
            crs_i = 1'($urandom);
            do_reset(s1, k[1]);
            expect_val("status pins", 0, {12'h000, 2'h3, crs_i, link_up_i}, 2);
            expect_val("straps", 5, {14'h0000, k[1], s1}, 2);
            expect_val("general enables", 1, {15'h0000, s1}, 2);
            if (s1)
                expect_val("clock pin", 6, 16'h0001, 3);
            step(3);
        end
        $display("test reset defaults done");
        gfunc = 14'h0008; // second general pin in output function while status codes cycle
        for (int c = 0; c < 16; c++)
        begin
            sf1 = c[1:0];
            sf2 = c[3:2];
            link_up_i = 1'($urandom);
            crs_i = 1'($urandom);
            gout = 7'($urandom);
            expect_val("status functions", 0, {12'h000, 2'h3, st_exp(sf2, crs_i, link_up_i),
                st_exp(sf1, link_up_i, crs_i)}, 2);
            expect_val("pin two output", 2, {14'h0000, gout[1], 1'b0}, 2);
            step(2);
        end
        $display("test status functions done");
        for (int r = 0; r < 24; r++)
            gp_round((r < 8) ? PAR_MII : (r < 16) ? PAR_RGMII : PAR_GMII);
        $display("test general functions done");
        par_mode_i = PAR_MII;
        gfunc = 14'h3FFF;
        ext_en = 7'h00;
        expect_val("clock enables", 1, 16'h007F, 2);
        expect_val("clock toggles", 6, 16'h007F, 3);
        step(4);
        $display("test clock function done");
        give_verdict();
    end
endmodule
